// *** rtl/sbw_pkg.sv ***
// shared types and constants for the byte-lane masked write path
package sbw_pkg;

  // ---------------------------------------------------------------
  // lane layout
  // ---------------------------------------------------------------
  localparam int LANE_W    = 9;
  localparam int MAX_LANES = 4;
  localparam int MAX_W     = LANE_W * MAX_LANES;
  localparam int BURST_LEN = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [MAX_W-1:0] DATA_RST = 36'h0_0000_0000;

  // ---------------------------------------------------------------
  // burst phases: each beat waits for its own input clock edge
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SBW_IDLE  = 3'b000,
    SBW_BEAT0 = 3'b001,
    SBW_BEAT1 = 3'b010,
    SBW_BEAT2 = 3'b011,
    SBW_BEAT3 = 3'b100
  } sbw_phase_t;

  // one data beat as driven by the controller
  typedef struct packed {
    logic [MAX_LANES-1:0] lane_sel_n;
    logic [MAX_W-1:0]     data;
  } sbw_beat_t;

endpackage : sbw_pkg

// *** rtl/sbw_lane_array.sv ***
// flip-flop storage array with one write enable per 9-bit lane
`timescale 1ns/1ps
`default_nettype none

module sbw_lane_array
  import sbw_pkg::*;
#(
  parameter int LANES  = 2,
  parameter int ADDR_W = 4
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic [LANES-1:0]          lane_we,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire logic [LANES*LANE_W-1:0]   wr_data,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output logic      [LANES*LANE_W-1:0]   rd_data
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int W     = LANES * LANE_W;

  logic [W-1:0] mem_r   [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [W-1:0] rd_data_nxt;

  // ---------------------------------------------------------------
  // lane-gated update
  // ---------------------------------------------------------------
  always_comb begin
    for (int e = 0; e < DEPTH; e++) begin
      mem_nxt[e] = mem_r[e];
    end
    // lane-wise enable
    // lanes not enabled keep their stored bits untouched
    for (int l = 0; l < LANES; l++) begin
      if (lane_we[l]) begin
        mem_nxt[wr_addr][l*LANE_W +: LANE_W] = wr_data[l*LANE_W +: LANE_W];
      end
    end
    rd_data_nxt = mem_r[rd_addr];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int e = 0; e < DEPTH; e++) begin
        mem_r[e] <= DATA_RST[W-1:0];
      end
      rd_data <= DATA_RST[W-1:0];
    end else begin
      for (int e = 0; e < DEPTH; e++) begin
        mem_r[e] <= mem_nxt[e];
      end
      rd_data <= rd_data_nxt;
    end
  end

endmodule : sbw_lane_array

`default_nettype wire

// *** rtl/sbw_write_path.sv ***
// burst write data path with per-beat byte-lane write masking
`timescale 1ns/1ps
`default_nettype none

module sbw_write_path
  import sbw_pkg::*;
#(
  parameter int LANES  = 2,
  parameter int ADDR_W = 4
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      k_rise_en,
  input  wire logic                      kb_rise_en,
  input  wire logic                      wr_sel_n,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire sbw_beat_t                 beat_in,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output logic      [LANES*LANE_W-1:0]   rd_data,
  output logic                           burst_busy
);

  localparam int W = LANES * LANE_W;

  // ---------------------------------------------------------------
  // burst sequencing state
  // ---------------------------------------------------------------
  sbw_phase_t        phase_r,    phase_nxt;
  logic [ADDR_W-1:0] base_r,     base_nxt;
  logic [ADDR_W-1:0] pend_r,     pend_nxt;
  logic              pend_v_r,   pend_v_nxt;

  logic              k_edge;
  logic              kb_edge;
  logic              beat_edge;
  logic [1:0]        beat_idx;
  logic [ADDR_W-1:0] beat_addr;
  logic [LANES-1:0]  lane_we;

  // K and K# never rise together; a cycle that flags both is taken as
  // no edge at all, so a glitch on the pulse pair cannot skip a beat
  assign k_edge  = k_rise_en & ~kb_rise_en;
  assign kb_edge = kb_rise_en & ~k_rise_en;

  always_comb begin
    phase_nxt = phase_r;
    base_nxt  = base_r;
    // address then four beats
    // data follows on K(t+1), K#(t+1), K(t+2), K#(t+2)
    unique case (phase_r)
      SBW_IDLE: begin
        if (k_edge && !wr_sel_n) begin
          base_nxt  = wr_addr;
          phase_nxt = SBW_BEAT0;
        end
      end
      // a write request on the K edge right after the one that
      // started this burst is ignored
      SBW_BEAT0: begin
        if (k_edge) begin
          phase_nxt = SBW_BEAT1;
        end
      end
      SBW_BEAT1: begin
        if (kb_edge) begin
          phase_nxt = SBW_BEAT2;
        end
      end
      SBW_BEAT2: begin
        if (k_edge) begin
          phase_nxt = SBW_BEAT3;
        end
      end
      SBW_BEAT3: begin
        if (kb_edge) begin
          if (pend_v_r) begin
            base_nxt  = pend_r;
            phase_nxt = SBW_BEAT0;
          end else begin
            phase_nxt = SBW_IDLE;
          end
        end
      end
      default: begin
        phase_nxt = SBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_r <= SBW_IDLE;
      base_r  <= '0;
    end else begin
      phase_r <= phase_nxt;
      base_r  <= base_nxt;
    end
  end

  // ---------------------------------------------------------------
  // follow-on request queue
  // ---------------------------------------------------------------
  always_comb begin
    pend_nxt   = pend_r;
    pend_v_nxt = pend_v_r;
    unique case (phase_r)
      // request at third beat
      // taken on the K edge of beat 2, it starts only after beat 3,
      // so two bursts never share one edge
      SBW_BEAT2: begin
        if (k_edge && !wr_sel_n) begin
          pend_nxt   = wr_addr;
          pend_v_nxt = 1'b1;
        end
      end
      SBW_BEAT3: begin
        if (kb_edge) begin
          pend_v_nxt = 1'b0;
        end
      end
      SBW_IDLE, SBW_BEAT0, SBW_BEAT1: begin
        pend_v_nxt = pend_v_r;
      end
      default: begin
        pend_v_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end else begin
      pend_r   <= pend_nxt;
      pend_v_r <= pend_v_nxt;
    end
  end

  // ---------------------------------------------------------------
  // beat qualification and lane enables
  // ---------------------------------------------------------------
  always_comb begin
    beat_edge = 1'b0;
    beat_idx  = 2'h0;
    unique case (phase_r)
      SBW_BEAT0: begin
        beat_edge = k_edge;
        beat_idx  = 2'h0;
      end
      SBW_BEAT1: begin
        beat_edge = kb_edge;
        beat_idx  = 2'h1;
      end
      SBW_BEAT2: begin
        beat_edge = k_edge;
        beat_idx  = 2'h2;
      end
      SBW_BEAT3: begin
        beat_edge = kb_edge;
        beat_idx  = 2'h3;
      end
      default: begin
        beat_edge = 1'b0;
        beat_idx  = 2'h0;
      end
    endcase
    // burst addresses run A, A+1, A+2, A+3 with wrap at the top
    beat_addr = base_r + ADDR_W'(beat_idx);
  end

  // per lane: ..all reduce to one active-high enable per lane
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      assign lane_we[l] = beat_edge & ~beat_in.lane_sel_n[l];
    end
  endgenerate

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // lane-wise array write
  sbw_lane_array #(
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_array (
    .clock   (clock),
    .rst_n   (rst_n),
    .lane_we (lane_we),
    .wr_addr (beat_addr),
    .wr_data (beat_in.data[W-1:0]),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign burst_busy = (phase_r != SBW_IDLE);

endmodule : sbw_write_path

`default_nettype wire

// *** test/sbw_write_path_props.sv ***
// checker for the masked burst write path
`timescale 1ns/1ps
`default_nettype none
module sbw_write_path_props
  import sbw_pkg::*;
#(
  parameter int LANES  = 2,
  parameter int ADDR_W = 4
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    k_rise_en,
  input wire logic                    kb_rise_en,
  input wire logic                    wr_sel_n,
  input wire logic [ADDR_W-1:0]       rd_addr,
  input wire logic [LANES*LANE_W-1:0] rd_data,
  input wire logic                    burst_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire cmd = k_rise_en && !wr_sel_n;

  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n
    |=> !burst_busy && rd_data == '0)
    else $error("busy or data left after reset");
  chk_busy_start: assert property (!burst_busy && cmd |=> burst_busy)
    else $error("command did not start a burst");
  chk_idle_stays: assert property (!burst_busy && !cmd |=> !burst_busy)
    else $error("burst started without a command");
  chk_rise_cause: assert property ($rose(burst_busy) |-> $past(cmd))
    else $error("busy rose with no command before it");
  chk_hold_quiet: assert property (burst_busy && !k_rise_en && !kb_rise_en |=> burst_busy)
    else $error("burst ended without a beat edge");
  chk_k_keeps: assert property (burst_busy && k_rise_en |=> burst_busy)
    else $error("burst ended on a true clock edge");
  chk_end_on_kb: assert property ($fell(burst_busy) |-> $past(kb_rise_en))
    else $error("burst end not after a complementary edge");
  chk_quiet_array: assert property (!burst_busy && !$past(burst_busy) && $stable(rd_addr)
    |=> $stable(rd_data))
    else $error("array changed outside a burst");
endmodule : sbw_write_path_props

bind sbw_write_path sbw_write_path_props #(.LANES(LANES), .ADDR_W(ADDR_W)) u_props (
  .clock(clock), .rst_n(rst_n), .k_rise_en(k_rise_en), .kb_rise_en(kb_rise_en),
  .wr_sel_n(wr_sel_n), .rd_addr(rd_addr), .rd_data(rd_data), .burst_busy(burst_busy));
`default_nettype wire

// *** test/sbw_ctrl_model.sv ***
// memory controller model driving commands and byte-lane beats
`timescale 1ns/1ps
`default_nettype none
module sbw_ctrl_model
  import sbw_pkg::*;
(
  input  wire logic       clock,
  output logic            k_rise_en,
  output logic            kb_rise_en,
  output logic            wr_sel_n,
  output logic [3:0]      wr_addr,
  output var sbw_beat_t   beat_in
);
  initial begin
    k_rise_en = 1'b0;
    kb_rise_en = 1'b0;
    wr_sel_n = 1'b1;
    wr_addr = '0;
    beat_in = '0;
  end

  task automatic pulse(input logic k, input logic s, input logic [3:0] a,
                       input sbw_beat_t b, input int gap);
    @(negedge clock);
    k_rise_en = k;
    kb_rise_en = !k;
    wr_sel_n = s;
    wr_addr = a;
    beat_in = b;
    @(negedge clock);
    k_rise_en = 1'b0;
    kb_rise_en = 1'b0;
    wr_sel_n = 1'b1;
    // released lines show the inverse so stale values never pass
    wr_addr = ~a;
    beat_in = ~b;
    repeat (gap) @(negedge clock);
  endtask : pulse

  // command on K, then beats on K, K#, K, K#
  // each beat carries its own lane pattern
  // a beat flagged in req_at also raises the write select with address nx:
  // refused on beat 0, queued as the next burst on beat 2
  task automatic burst(input logic [3:0] a, input sbw_beat_t b [4], input int gap,
                       input logic cmd, input logic [3:0] req_at, input logic [3:0] nx);
    if (cmd) pulse(1'b1, 1'b0, a, '1, gap);
    for (int i = 0; i < 4; i++) begin
      pulse(i % 2 == 0, !req_at[i], req_at[i] ? nx : ~a, b[i], gap);
    end
  endtask : burst
endmodule : sbw_ctrl_model
`default_nettype wire

// *** test/sbw_write_path_tb.sv ***
// self-checking bench for the masked burst write path
`timescale 1ns/1ps
`default_nettype none
module sbw_write_path_tb
  import sbw_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        k_rise_en;
  logic        kb_rise_en;
  logic        wr_sel_n;
  logic [3:0]  wr_addr;
  logic [3:0]  rd_addr = 4'h0;
  sbw_beat_t   beat_in;
  logic [35:0] rd_data;
  logic [17:0] rd_data_n;
  logic        burst_busy;
  logic        burst_busy_n;
  logic [35:0] exp_mem [16] = '{default: 36'h0_0000_0000};
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #12.5 clock = ~clock;

  sbw_ctrl_model ctrl (.clock(clock), .k_rise_en(k_rise_en), .kb_rise_en(kb_rise_en),
    .wr_sel_n(wr_sel_n), .wr_addr(wr_addr), .beat_in(beat_in));
  sbw_write_path #(.LANES(4), .ADDR_W(4)) DUT (.clock(clock), .rst_n(rst_n),
    .k_rise_en(k_rise_en), .kb_rise_en(kb_rise_en), .wr_sel_n(wr_sel_n), .wr_addr(wr_addr),
    .beat_in(beat_in), .rd_addr(rd_addr), .rd_data(rd_data), .burst_busy(burst_busy));
  sbw_write_path #(.LANES(2), .ADDR_W(4)) DUT2 (.clock(clock), .rst_n(rst_n),
    .k_rise_en(k_rise_en), .kb_rise_en(kb_rise_en), .wr_sel_n(wr_sel_n), .wr_addr(wr_addr),
    .beat_in(beat_in), .rd_addr(rd_addr), .rd_data(rd_data_n), .burst_busy(burst_busy_n));

  task automatic check(input logic [35:0] got, input logic [35:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // beat i uses sel[4i+3:4i]; lane data differs per beat and lane
  task automatic wr(input logic [3:0] a, input logic [15:0] sel, input logic [8:0] base,
                    input int gap, input logic cmd = 1'b1, input logic [3:0] req_at = 4'h0,
                    input logic [3:0] nx = 4'h0);
    sbw_beat_t  b [4];
    logic [3:0] ad;
    for (int i = 0; i < 4; i++) begin
      ad = a + 4'(i);
      b[i].lane_sel_n = sel[4*i +: 4];
      for (int l = 0; l < 4; l++) begin
        b[i].data[9*l +: 9] = base + 9'(4*i + l);
        if (!b[i].lane_sel_n[l]) exp_mem[ad][9*l +: 9] = b[i].data[9*l +: 9];
      end
    end
    ctrl.burst(a, b, gap, cmd, req_at, nx);
  endtask : wr

  task automatic verify();
    check({34'h0, burst_busy_n, burst_busy}, 36'h0_0000_0000);
    for (int a = 0; a < 16; a++) begin
      @(negedge clock);
      rd_addr = 4'(a);
      repeat (2) @(negedge clock);
      check(rd_data, exp_mem[a]);
      check({18'h0, rd_data_n}, {18'h0, exp_mem[a][17:0]});
    end
  endtask : verify

  task automatic t_single_lanes();
    wr(4'h3, 16'h7BDE, 9'h011, 0);
    verify();
  endtask : t_single_lanes

  task automatic t_all_or_none();
    wr(4'h3, 16'hF0F0, 9'h1A0, 2);
    verify();
  endtask : t_all_or_none

  // two bursts, the second sent after the first ends; mixed patterns, address wrap
  task automatic t_mixed_wrap();
    wr(4'hE, 16'h965A, 9'h0C4, 1);
    wr(4'h2, 16'h3C81, 9'h150, 0);
    verify();
  endtask : t_mixed_wrap

  // request on beat 0 is refused, one on beat 2 queues the next burst
  task automatic t_queued();
    wr(4'h9, 16'h0000, 9'h0E0, 0, 1'b1, 4'h5, 4'hB);
    check({34'h0, burst_busy_n, burst_busy}, 36'h0_0000_0003);
    wr(4'hB, 16'h1248, 9'h1C8, 0, 1'b0);
    verify();
  endtask : t_queued

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    verify();
    t_single_lanes();
    t_all_or_none();
    t_mixed_wrap();
    t_queued();
    summarize();
  end
endmodule : sbw_write_path_tb
`default_nettype wire
